// ===== lcc_pkg.sv
// Behaviour
// - Fifteen fixed operating states, from power down through fault and suspend.
// - Input above power-on but below battery plus margin keeps sleep, no charging.
// - Input above battery plus margin, under over-voltage: power good low, pin check.
// - No pin short enables output regulation at 100mA limit, then output check.
// - Output below 0.9V holds the output check state as a short.
// - Output above 0.9V picks input limit from source and mode, samples enable.
// - Enable low enters battery short check, sourcing 5.5mA, comparing 1.8V.
// - Battery above 1.8V starts trickle, trickle timer and charge indicator low.
// - Battery at 3.0V starts fast charge at smaller of set and input limit.
// - Battery at 4.2V switches constant current to constant voltage.
// - Current under end-of-charge releases charge indicator high.
// - After end of charge, current stops only with continuous supply low.
// - After completion, recharge once battery falls 120mV under regulation.
// - Fast charge picks full, shared-path or battery supplement by load.
// - Output target battery plus 225mV above 3.2V, else fixed 3.4V.
// - Timer expiry before completion: fault, power good low, blink, charger off.
// - Fault stays latched until input power is removed and reapplied.
// - Die over-temperature forces suspend: indicator frozen, charger off, output from battery.
// - Leave suspend after cooling by hysteresis and resume prior operation.
// - Safety timer pauses while continuous supply select is high.
// - Thermistor out of window pauses charging and timer, indicator stays low.
package lcc_pkg;

  typedef enum logic [3:0] {
    ST_POWER_DOWN, ST_SLEEP, ST_STANDBY, ST_PIN_CHECK, ST_SYSTEM_OUTPUT_VOLTAGE_CHECK,
    ST_IDLE, ST_VBAT_CHECK, ST_TRICKLE, ST_FAST, ST_COMPLETE,
    ST_DETECT1, ST_DETECT2, ST_DETECT3, ST_FAULT, ST_SUSPEND
  } lcc_state_e;

  typedef enum logic [1:0] {CUR_OFF, CUR_TRICKLE, CUR_FAST} lcc_cur_e;
  typedef enum logic [1:0] {FM_FULL, FM_SHARED, FM_SUPPLEMENT} lcc_fast_e;

  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int TICK_MS = 1;
  localparam int BLINK_MS = 500;
  localparam int BLINK_HALF_TICKS = BLINK_MS / (2 * TICK_MS);

  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_TIMEOUT = 4'h4;
  localparam logic [3:0] REG_TIMER = 4'h8;
  localparam int TMR_W = 24;
  localparam logic [TMR_W-1:0] TIMEOUT_RST = 24'h36_ee80;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_PG_BIT = 4;
  localparam int ST_CHG_BIT = 5;
  localparam int ST_CV_BIT = 6;
  localparam int ST_FAST_LSB = 7;
  localparam int ST_ON_BIT = 9;

endpackage : lcc_pkg

// ===== lcc_sync.sv
module lcc_sync #(
  parameter int W = 1
) (
  input wire logic clock_i,          // System clock
  input wire logic srst_i,           // Sync reset
  input wire logic [W-1:0] async_i,  // Raw inputs
  output logic [W-1:0] sync_o        // Filtered inputs
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;

  // --------------------------------------------------------------
  // Three stages, accept when stages two and three agree
  // --------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      out_r <= '0;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          out_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign sync_o = out_r;
endmodule : lcc_sync

// ===== lcc_charger.sv
module lcc_charger
  import lcc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic clock_i,                 // 20 MHz oscillator
  input wire logic srst_i,                  // Sync reset, high
  input wire logic vin_above_por_i,         // Input above power-on threshold
  input wire logic vin_above_bat_os_i,      // Input above battery plus margin
  input wire logic vin_above_ovp_i,         // Input above over-voltage limit
  input wire logic input_limit_set_pin_pin_short_i,        // Input limit set pin shorted
  input wire logic charge_current_set_pin_pin_short_i,        // Charge current set pin shorted
  input wire logic system_output_voltage_above_0v9_i,        // Output above 0.9V
  input wire logic source_type_sel_i,       // Source type strap
  input wire logic mode_i,                  // Mode strap
  input wire logic charge_enable_n_i,       // Charge enable, low active
  input wire logic vbat_above_1v8_i,        // Battery above 1.8V
  input wire logic vbat_above_min_i,        // Battery above precharge threshold
  input wire logic vbat_at_reg_i,           // Battery at regulated level
  input wire logic ichg_below_eoc_i,        // Charge current under end of charge
  input wire logic vbat_below_rch_i,        // Battery under recharge threshold
  input wire logic continuous_supply_sel_i, // Continuous supply strap
  input wire logic die_over_temp_i,         // Die at over-temperature
  input wire logic die_cooled_i,            // Die cooled by hysteresis
  input wire logic ntc_in_window_i,         // Thermistor in valid window
  input wire logic vbat_above_3v2_i,        // Battery above 3.2V
  input wire logic load_chg_over_lim_i,     // Load plus charge over limit
  input wire logic load_over_lim_i,         // Load alone over limit
  output logic power_good_n_o,              // Power good pin level
  output logic power_good_n_oe_o,           // Power good pull low
  output logic charge_ind_n_o,              // Charge indicator pin level
  output logic charge_ind_n_oe_o,           // Charge indicator pull low
  output logic out_reg_en_o,                // Output regulation on
  output logic out_input_limit_set_pin_100ma_o,            // 100mA output current limit
  output logic [1:0] in_input_limit_set_pin_sel_o,         // Input limit {source, mode}
  output logic bat_test_src_o,              // 5.5mA battery test source
  output logic charge_on_o,                 // Charger switched on
  output logic [1:0] charge_cur_sel_o,      // Current target select
  output logic cv_mode_o,                   // Constant-voltage mode
  output logic [1:0] fast_mode_o,           // Fast charge sub-mode
  output logic system_output_voltage_target_sel_o,           // 1: battery plus 225mV, 0: 3.4V
  output logic system_output_voltage_from_bat_o,             // Output fed from battery
  input wire logic [3:0] avs_address_i,     // Byte address
  input wire logic avs_read_i,              // Read strobe
  input wire logic avs_write_i,             // Write strobe
  input wire logic [31:0] avs_writedata_i,  // Write data
  input wire logic [3:0] avs_byteenable_i,  // Byte enables
  output logic [31:0] avs_readdata_o,       // Read data
  output logic avs_waitrequest_o            // Wait request
);

  localparam int NIN = 21;
  localparam int TCW = $clog2(TICK_CYCLES);
  localparam int BCW = $clog2(BLINK_HALF_TICKS);
  localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES - 1);
  localparam logic [BCW-1:0] BLINK_LAST = BCW'(BLINK_HALF_TICKS - 1);

  typedef struct packed {
    lcc_state_e st;
    lcc_state_e ret;
    logic [TCW-1:0] tick_cnt;
    logic tick;
    logic [BCW-1:0] blink_cnt;
    logic [TMR_W-1:0] timer;
    logic [TMR_W-1:0] limit;
    logic pg_oe;
    logic chg_oe;
    logic out_reg;
    logic ilim100;
    logic [1:0] in_input_limit_set_pin;
    logic bat_src;
    logic chg_on;
    lcc_cur_e cur;
    logic cv;
    lcc_fast_e fmode;
    logic vsel;
    logic from_bat;
    logic waitreq;
    logic [31:0] rdata;
  } lcc_state_s;

  lcc_state_s r;
  lcc_state_s n;

  logic [NIN-1:0] pins_s;
  logic por, vin_win, vin_ovp, pin_short_a, pin_short_b, system_output_voltage_ok, src, mode;
  logic en_n, v1v8, precharge_threshold, vreg, eoc, rch, continuous_supply_sel, ot, cool, ntc, v3v2, sum_ov, ld_ov;
  logic vin_ok;
  logic charging;

  // --------------------------------------------------------------
  // Input synchroniser
  // --------------------------------------------------------------
  lcc_sync #(.W(NIN)) u_sync (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .async_i({vin_above_por_i, vin_above_bat_os_i, vin_above_ovp_i, input_limit_set_pin_pin_short_i,
              charge_current_set_pin_pin_short_i, system_output_voltage_above_0v9_i, source_type_sel_i, mode_i,
              charge_enable_n_i, vbat_above_1v8_i, vbat_above_min_i, vbat_at_reg_i,
              ichg_below_eoc_i, vbat_below_rch_i, continuous_supply_sel_i,
              die_over_temp_i, die_cooled_i, ntc_in_window_i, vbat_above_3v2_i,
              load_chg_over_lim_i, load_over_lim_i}),
    .sync_o(pins_s)
  );

  assign {por, vin_win, vin_ovp, pin_short_a, pin_short_b, system_output_voltage_ok, src, mode,
          en_n, v1v8, precharge_threshold, vreg, eoc, rch, continuous_supply_sel, ot, cool, ntc, v3v2, sum_ov,
          ld_ov} = pins_s;

  assign vin_ok = vin_win && !vin_ovp;
  assign charging = (r.st == ST_TRICKLE) || (r.st == ST_FAST);

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    n = r;
    // Millisecond enable
    n.tick = (r.tick_cnt == TICK_LAST);
    n.tick_cnt = n.tick ? '0 : r.tick_cnt + 1'b1;

    // Safety timer, paused by strap or thermistor
    if (charging && r.tick && !continuous_supply_sel && ntc) begin
      n.timer = r.timer + 1'b1;
    end

    // Sequencing
    if (!por) begin
      n.st = ST_POWER_DOWN;
    end else if (ot && r.st != ST_SUSPEND && r.st != ST_POWER_DOWN) begin
      n.st = ST_SUSPEND;
      n.ret = r.st;
    end else begin
      case (r.st)
        ST_POWER_DOWN: begin
          n.st = ST_SLEEP;
        end
        ST_SLEEP: begin
          if (vin_ok) begin
            n.st = ST_PIN_CHECK;
          end
        end
        ST_PIN_CHECK: begin
          if (!vin_ok) begin
            n.st = ST_SLEEP;
          end else if (!pin_short_a && !pin_short_b) begin
            n.st = ST_SYSTEM_OUTPUT_VOLTAGE_CHECK;
          end
        end
        ST_SYSTEM_OUTPUT_VOLTAGE_CHECK: begin
          if (!vin_ok) begin
            n.st = ST_SLEEP;
          end else if (system_output_voltage_ok) begin
            n.st = ST_IDLE;
            n.in_input_limit_set_pin = {src, mode};
          end
        end
        ST_IDLE, ST_STANDBY: begin
          if (!vin_ok) begin
            n.st = ST_SLEEP;
          end else if (!en_n) begin
            n.st = ST_VBAT_CHECK;
          end else begin
            n.st = ST_STANDBY;
          end
        end
        ST_VBAT_CHECK: begin
          if (!vin_ok) begin
            n.st = ST_SLEEP;
          end else if (en_n) begin
            n.st = ST_STANDBY;
          end else if (v1v8) begin
            n.st = ST_TRICKLE;
            n.timer = '0;
          end
        end
        ST_TRICKLE, ST_FAST: begin
          if (!vin_ok) begin
            n.st = ST_SLEEP;
          end else if (en_n) begin
            n.st = ST_STANDBY;
          end else if (r.timer >= r.limit) begin
            n.st = ST_FAULT;
          end else if (r.st == ST_TRICKLE && precharge_threshold) begin
            n.st = ST_FAST;
          end else if (r.st == ST_FAST && r.cv && eoc) begin
            n.st = ST_COMPLETE;
          end
        end
        ST_COMPLETE: begin
          if (!vin_ok) begin
            n.st = ST_SLEEP;
          end else if (en_n) begin
            n.st = ST_STANDBY;
          end else if (rch) begin
            n.st = ST_FAST;
            n.timer = '0;
          end
        end
        ST_FAULT: begin
          n.st = ST_FAULT;
        end
        ST_SUSPEND: begin
          if (cool && !ot) begin
            n.st = r.ret;
          end
        end
        default: begin
          n.st = ST_SLEEP;
        end
      endcase
    end

    // Constant-voltage latch within fast charge
    if (n.st != ST_FAST && n.st != ST_COMPLETE) begin
      n.cv = 1'b0;
    end else if (vreg) begin
      n.cv = 1'b1;
    end

    // Fault blink divider
    if (n.st != ST_FAULT) begin
      n.blink_cnt = '0;
    end else if (r.tick) begin
      n.blink_cnt = (r.blink_cnt == BLINK_LAST) ? '0 : r.blink_cnt + 1'b1;
      if (r.blink_cnt == BLINK_LAST) begin
        n.chg_oe = !r.chg_oe;
      end
    end

    // Per-state outputs
    n.pg_oe = !(n.st inside {ST_POWER_DOWN, ST_SLEEP});
    n.out_reg = !(n.st inside {ST_POWER_DOWN, ST_SLEEP, ST_PIN_CHECK, ST_SUSPEND});
    n.ilim100 = (n.st == ST_SYSTEM_OUTPUT_VOLTAGE_CHECK);
    n.bat_src = (n.st == ST_VBAT_CHECK);
    n.from_bat = (n.st == ST_SUSPEND);
    n.vsel = v3v2;
    n.chg_on = 1'b0;
    n.cur = CUR_OFF;
    case (n.st)
      ST_TRICKLE: begin
        n.chg_on = ntc;
        n.cur = CUR_TRICKLE;
        n.chg_oe = 1'b1;
      end
      ST_FAST: begin
        n.chg_on = ntc;
        n.cur = CUR_FAST;
        n.chg_oe = 1'b1;
      end
      ST_COMPLETE: begin
        n.chg_on = continuous_supply_sel && ntc;
        n.cur = continuous_supply_sel ? CUR_FAST : CUR_OFF;
        n.chg_oe = 1'b0;
      end
      ST_FAULT, ST_SUSPEND: begin
        n.chg_on = 1'b0;
      end
      default: begin
        n.chg_oe = 1'b0;
      end
    endcase

    // Fast charge sub-mode
    if (ld_ov) begin
      n.fmode = FM_SUPPLEMENT;
    end else if (sum_ov) begin
      n.fmode = FM_SHARED;
    end else begin
      n.fmode = FM_FULL;
    end

    // Avalon slave: one wait cycle, then accept
    n.waitreq = 1'b1;
    if ((avs_read_i || avs_write_i) && r.waitreq) begin
      n.waitreq = 1'b0;
      case (avs_address_i)
        REG_STATUS: begin
          n.rdata = '0;
          n.rdata[ST_STATE_LSB +: 4] = r.st;
          n.rdata[ST_PG_BIT] = r.pg_oe;
          n.rdata[ST_CHG_BIT] = r.chg_oe;
          n.rdata[ST_CV_BIT] = r.cv;
          n.rdata[ST_FAST_LSB +: 2] = r.fmode;
          n.rdata[ST_ON_BIT] = r.chg_on;
        end
        REG_TIMEOUT: begin
          n.rdata = {8'h00, r.limit};
        end
        REG_TIMER: begin
          n.rdata = {8'h00, r.timer};
        end
        default: begin
          n.rdata = '0;
        end
      endcase
    end
    if (avs_write_i && !r.waitreq && avs_address_i == REG_TIMEOUT) begin
      for (int b = 0; b < 3; b++) begin
        if (avs_byteenable_i[b]) begin
          n.limit[8*b +: 8] = avs_writedata_i[8*b +: 8];
        end
      end
    end
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      r <= '0;
      r.waitreq <= 1'b1;
      r.limit <= TIMEOUT_RST;
    end else begin
      r <= n;
    end
  end

  assign power_good_n_o = 1'b0;
  assign power_good_n_oe_o = r.pg_oe;
  assign charge_ind_n_o = 1'b0;
  assign charge_ind_n_oe_o = r.chg_oe;
  assign out_reg_en_o = r.out_reg;
  assign out_input_limit_set_pin_100ma_o = r.ilim100;
  assign in_input_limit_set_pin_sel_o = r.in_input_limit_set_pin;
  assign bat_test_src_o = r.bat_src;
  assign charge_on_o = r.chg_on;
  assign charge_cur_sel_o = r.cur;
  assign cv_mode_o = r.cv;
  assign fast_mode_o = r.fmode;
  assign system_output_voltage_target_sel_o = r.vsel;
  assign system_output_voltage_from_bat_o = r.from_bat;
  assign avs_readdata_o = r.rdata;
  assign avs_waitrequest_o = r.waitreq;

endmodule : lcc_charger

// ===== lcc_charger_checker.sv
module lcc_charger_checker
  import lcc_pkg::*;
(
  input wire logic clock_i, // Clock
  input wire logic srst_i, // Reset
  input wire logic vin_above_por_i, // Power on
  input wire logic vin_above_bat_os_i, // Input margin
  input wire logic charge_enable_n_i, // Enable
  input wire logic die_over_temp_i, // Hot die
  input wire logic vbat_above_3v2_i, // Battery high
  input wire logic avs_read_i, // Read
  input wire logic avs_write_i, // Write
  input wire logic power_good_n_oe_o, // Good pull
  input wire logic charge_ind_n_oe_o, // Indicator pull
  input wire logic out_reg_en_o, // Regulation
  input wire logic out_input_limit_set_pin_100ma_o, // Low limit
  input wire logic bat_test_src_o, // Test source
  input wire logic charge_on_o, // Charger
  input wire logic [1:0] charge_cur_sel_o, // Current
  input wire logic cv_mode_o, // Voltage mode
  input wire logic system_output_voltage_target_sel_o, // Target
  input wire logic system_output_voltage_from_bat_o, // From battery
  input wire logic avs_waitrequest_o // Wait
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  chk_sleep_idle: assert property (!vin_above_bat_os_i [*8] |=> !charge_on_o)
    else $error("charger on without input margin");
  chk_good_charge: assert property (charge_on_o |-> power_good_n_oe_o)
    else $error("charger on without power good");
  chk_out_limit: assert property (out_input_limit_set_pin_100ma_o |-> out_reg_en_o && !charge_on_o)
    else $error("output check without regulation");
  chk_enable_gate: assert property (charge_enable_n_i [*8] |=> !charge_on_o)
    else $error("charger on while disabled");
  chk_test_src: assert property (bat_test_src_o |-> !charge_on_o)
    else $error("test source while charging");
  chk_cur_select: assert property (charge_on_o |-> charge_cur_sel_o != 2'(CUR_OFF))
    else $error("charger on with no current");
  chk_cv_fast: assert property (cv_mode_o && charge_on_o |-> charge_cur_sel_o == 2'(CUR_FAST))
    else $error("voltage mode without fast current");
  chk_target_high: assert property (vbat_above_3v2_i [*8] |=> system_output_voltage_target_sel_o)
    else $error("target not tracking battery");
  chk_target_low: assert property (!vbat_above_3v2_i [*8] |=> !system_output_voltage_target_sel_o)
    else $error("target not fixed");
  chk_hot_entry: assert property ((die_over_temp_i && vin_above_por_i) [*8] |->
    ##[0:4] (system_output_voltage_from_bat_o && !charge_on_o))
    else $error("no suspend on hot die");
  chk_ind_frozen: assert property (system_output_voltage_from_bat_o |-> $stable(charge_ind_n_oe_o))
    else $error("indicator moved in suspend");
  chk_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("wait low too long");
  chk_bus_taken: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o)
    else $error("bus request not answered");

  cov_hot: cover property ($rose(system_output_voltage_from_bat_o));
  cov_test: cover property (bat_test_src_o);
  cov_cv: cover property (cv_mode_o && charge_on_o);
  cov_write: cover property (!avs_waitrequest_o && avs_write_i);
endmodule : lcc_charger_checker

bind lcc_charger lcc_charger_checker i_chk (.clock_i(clock_i), .srst_i(srst_i),
  .vin_above_por_i(vin_above_por_i), .vin_above_bat_os_i(vin_above_bat_os_i),
  .charge_enable_n_i(charge_enable_n_i), .die_over_temp_i(die_over_temp_i),
  .vbat_above_3v2_i(vbat_above_3v2_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .power_good_n_oe_o(power_good_n_oe_o), .charge_ind_n_oe_o(charge_ind_n_oe_o),
  .out_reg_en_o(out_reg_en_o), .out_input_limit_set_pin_100ma_o(out_input_limit_set_pin_100ma_o),
  .bat_test_src_o(bat_test_src_o), .charge_on_o(charge_on_o),
  .charge_cur_sel_o(charge_cur_sel_o), .cv_mode_o(cv_mode_o),
  .system_output_voltage_target_sel_o(system_output_voltage_target_sel_o), .system_output_voltage_from_bat_o(system_output_voltage_from_bat_o),
  .avs_waitrequest_o(avs_waitrequest_o));

// ===== lcc_host.sv
module lcc_host (
  input wire logic clock_i, // Clock
  input wire logic power_good_n_i, // Pin level
  input wire logic power_good_n_oe_i, // Pin pulled
  input wire logic charge_ind_n_i, // Pin level
  input wire logic charge_ind_n_oe_i, // Pin pulled
  output logic good_line_n_o, // Resolved line
  output logic ind_line_n_o, // Resolved line
  output int ind_edges_o // Indicator changes
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev = 1'b1;
  // Pull-ups hold released lines high
  assign good_line_n_o = power_good_n_oe_i ? power_good_n_i : 1'b1;
  assign ind_line_n_o = charge_ind_n_oe_i ? charge_ind_n_i : 1'b1;
  initial ind_edges_o = 0;
  always @(posedge clock_i) begin
    prev <= ind_line_n_o;
    if (prev !== ind_line_n_o) begin
      ind_edges_o <= ind_edges_o + 1;
    end
  end
endmodule : lcc_host

// ===== lcc_charger_tb_top.sv
module lcc_charger_tb_top
  import lcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POR = 0, BOS = 1, OVER_VOLTAGE_LIMIT = 2, ILS = 3, IRS = 4, VO = 5, SRC = 6, MD = 7, EN = 8;
  localparam int B18 = 9, BMIN = 10, BREG = 11, EOC = 12, RCH = 13, CNT = 14, OT = 15;
  localparam int COOL = 16, NTC = 17, B32 = 18, LCO = 19, LO = 20;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [20:0] c;
  logic [3:0] avs_addr = 4'h0;
  logic avs_rd = 1'b0;
  logic avs_wr = 1'b0;
  logic [3:0] avs_be = 4'hf;
  logic [31:0] avs_wdata = 32'h0000_0000;
  logic [31:0] rdata, q, r, t;
  logic wreq, good_n, good_oe, ind_n, ind_oe, reg_en, lim100, test_src, charging, cv, tsel;
  logic from_bat, good_line, ind_line;
  logic [1:0] lim_sel, cur_sel, fmode;
  int ind_edges, e0;
  int errors = 0;
  int checks_done = 0;
  int seed = 32'heed0558f;

  always #25 clock = ~clock;

  lcc_charger #(.TICK_CYCLES(4)) i_dut (.clock_i(clock), .srst_i(srst),
    .vin_above_por_i(c[POR]), .vin_above_bat_os_i(c[BOS]), .vin_above_ovp_i(c[OVER_VOLTAGE_LIMIT]),
    .input_limit_set_pin_pin_short_i(c[ILS]), .charge_current_set_pin_pin_short_i(c[IRS]), .system_output_voltage_above_0v9_i(c[VO]),
    .source_type_sel_i(c[SRC]), .mode_i(c[MD]), .charge_enable_n_i(c[EN]),
    .vbat_above_1v8_i(c[B18]), .vbat_above_min_i(c[BMIN]), .vbat_at_reg_i(c[BREG]),
    .ichg_below_eoc_i(c[EOC]), .vbat_below_rch_i(c[RCH]), .continuous_supply_sel_i(c[CNT]),
    .die_over_temp_i(c[OT]), .die_cooled_i(c[COOL]), .ntc_in_window_i(c[NTC]),
    .vbat_above_3v2_i(c[B32]), .load_chg_over_lim_i(c[LCO]), .load_over_lim_i(c[LO]),
    .power_good_n_o(good_n), .power_good_n_oe_o(good_oe), .charge_ind_n_o(ind_n),
    .charge_ind_n_oe_o(ind_oe), .out_reg_en_o(reg_en), .out_input_limit_set_pin_100ma_o(lim100),
    .in_input_limit_set_pin_sel_o(lim_sel), .bat_test_src_o(test_src), .charge_on_o(charging),
    .charge_cur_sel_o(cur_sel), .cv_mode_o(cv), .fast_mode_o(fmode),
    .system_output_voltage_target_sel_o(tsel), .system_output_voltage_from_bat_o(from_bat), .avs_address_i(avs_addr),
    .avs_read_i(avs_rd), .avs_write_i(avs_wr), .avs_writedata_i(avs_wdata),
    .avs_byteenable_i(avs_be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq));

  lcc_host i_host (.clock_i(clock), .power_good_n_i(good_n), .power_good_n_oe_i(good_oe),
    .charge_ind_n_i(ind_n), .charge_ind_n_oe_i(ind_oe), .good_line_n_o(good_line),
    .ind_line_n_o(ind_line), .ind_edges_o(ind_edges));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic bit1(input logic got, input logic exp);
    cmp({31'h0, got}, {31'h0, exp});
  endtask : bit1

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_addr <= a;
    avs_wdata <= d;
    avs_wr <= wr;
    avs_rd <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
    if (n >= 50) begin
      errors++;
      $display("ERROR %0t: bus hang", $time);
    end
    @(posedge clock);
  endtask : bus

  task automatic put(input int i, input logic v);
    c[i] <= v;
    repeat (12) @(posedge clock);
  endtask : put

  // Model of state number and the pins that follow it
  task automatic look(input int st);
    bus(1'b0, REG_STATUS, ZERO);
    cmp({28'h0, q[3:0]}, 32'(st));
    bit1(good_line, st < 2);
    bit1(test_src, st == 6);
    bit1(lim100, st == 4);
    bit1(from_bat, st == 14);
  endtask : look

  task automatic timer_frozen;
    bus(1'b0, REG_TIMER, ZERO);
    t = q;
    repeat (40) @(posedge clock);
    bus(1'b0, REG_TIMER, ZERO);
  endtask : timer_frozen

  initial begin
    repeat (10000) @(posedge clock);
    errors++;
    $display("ERROR %0t: watchdog expired", $time);
    end_of_test();
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    c = 21'h0;
    c[EN] = 1'b1;
    c[NTC] = 1'b1;
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    bus(1'b0, REG_TIMEOUT, ZERO);
    cmp(q, {8'h00, TIMEOUT_RST});
    r = $random(seed);
    bus(1'b1, REG_TIMEOUT, r);
    bus(1'b0, REG_TIMEOUT, ZERO);
    cmp(q, r & 32'h00ff_ffff);
    avs_be <= 4'h2;
    bus(1'b1, REG_TIMEOUT, ~r);
    avs_be <= 4'hf;
    bus(1'b0, REG_TIMEOUT, ZERO);
    cmp(q, {8'h00, r[23:16], ~r[15:8], r[7:0]});
    bus(1'b1, 4'hc, r);
    bus(1'b0, 4'hc, ZERO);
    cmp(q, ZERO);
    bus(1'b1, REG_STATUS, r);
    look(0);
    bus(1'b1, REG_TIMEOUT, 32'h0000_ffff);
    $display("test registers done");
    put(POR, 1'b1);
    look(1);
    put(ILS, 1'b1);
    put(BOS, 1'b1);
    look(3);
    c[ILS] <= 1'b0;
    put(IRS, 1'b1);
    look(3);
    put(IRS, 1'b0);
    look(4);
    bit1(reg_en, 1'b1);
    c[SRC] <= r[0];
    c[MD] <= r[1];
    put(VO, 1'b1);
    look(2);
    cmp({30'h0, lim_sel}, {30'h0, r[0], r[1]});
    put(EN, 1'b0);
    look(6);
    put(B18, 1'b1);
    look(7);
    bit1(ind_line, 1'b0);
    cmp(32'(cur_sel), 32'(CUR_TRICKLE));
    timer_frozen();
    bit1(q > t, 1'b1);
    put(CNT, 1'b1);
    timer_frozen();
    cmp(q, t);
    c[CNT] <= 1'b0;
    put(NTC, 1'b0);
    bit1(charging, 1'b0);
    bit1(ind_line, 1'b0);
    timer_frozen();
    cmp(q, t);
    put(NTC, 1'b1);
    bit1(charging, 1'b1);
    put(BMIN, 1'b1);
    look(8);
    cmp(32'(cur_sel), 32'(CUR_FAST));
    for (int i = 0; i < 3; i++) begin
      c[LCO] <= i > 0;
      c[LO] <= i == 2;
      put(B32, i[0]);
      cmp(32'(fmode), 32'(i));
      bit1(tsel, i[0]);
    end
    $display("test charge flow done");
    put(OT, 1'b1);
    look(14);
    bit1(ind_line, 1'b0);
    c[OT] <= 1'b0;
    put(COOL, 1'b1);
    look(8);
    put(COOL, 1'b0);
    put(BREG, 1'b1);
    bit1(cv, 1'b1);
    put(EOC, 1'b1);
    look(9);
    bit1(ind_line, 1'b1);
    bit1(charging, 1'b0);
    put(CNT, 1'b1);
    bit1(charging, 1'b1);
    put(CNT, 1'b0);
    c[BREG] <= 1'b0;
    c[EOC] <= 1'b0;
    put(RCH, 1'b1);
    bit1(charging, 1'b1);
    bit1(ind_line, 1'b0);
    put(RCH, 1'b0);
    $display("test protection done");
    bus(1'b1, REG_TIMEOUT, 32'h0000_0001);
    repeat (20) @(posedge clock);
    look(13);
    bit1(charging, 1'b0);
    e0 = ind_edges;
    repeat (2000) @(posedge clock);
    cmp(32'(ind_edges - e0), 32'h0000_0002);
    c[OVER_VOLTAGE_LIMIT] <= 1'b1;
    put(BOS, 1'b0);
    look(13);
    c[OVER_VOLTAGE_LIMIT] <= 1'b0;
    put(POR, 1'b0);
    look(0);
    put(POR, 1'b1);
    look(1);
    $display("test fault done");
    end_of_test();
  end
endmodule : lcc_charger_tb_top
